/* File: pioiu_top.sv */
// Purpose: executes port input/output instructions issued over avalon-mm
// Assumes: one clock CLK_SYS at 100 MHz, synchronous active-high SYS_RST
// Notes:   a write to the command register executes one instruction
//
// Behaviour
// - port_zero read copies the four port_zero pin levels into working_register.
// - port_zero write drives working_register onto port_zero output latches.
// - port_one supports read into and write from working_register.
// - port_two read places its two pin levels in working_register bits 1:0.
// - port_two write drives working_register bits 1:0 to port_two latches.
// - port_three read places its two pin levels in working_register bits 1:0.
// - port_three write drives working_register bits 1:0 to port_three latches.
// - strobe bit-clear zeroes only the bit chosen by bit_pointer.
// - strobe bit-set ones only the bit chosen by bit_pointer.
// - strobe test skips next instruction when chosen bit is zero; pointer 0..5.
// - two instructions set and clear flag_output_pin, working_register untouched.
// - flag test skips next instruction when flag_output_pin is one.
// - single pin read loads the pin level into working_register bit 0.
// - single pin write drives working_register bit 0 onto its output latch.
// - three instructions copy working_register into the wake-on-key controls.
// - three instructions return the wake-on-key controls into working_register.
// - three instructions copy working_register into pull-up controls, write only.
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pioiu_top import pioiu_pkg::*; (
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    input  wire logic [5:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic [3:0]  PORT_ZERO_IN,
    output logic      [3:0]  PORT_ZERO_OUT,
    input  wire logic [3:0]  PORT_ONE_IN,
    output logic      [3:0]  PORT_ONE_OUT,
    input  wire logic [1:0]  PORT_TWO_IN,
    output logic      [1:0]  PORT_TWO_OUT,
    input  wire logic [1:0]  PORT_THREE_IN,
    output logic      [1:0]  PORT_THREE_OUT,
    output logic      [5:0]  OUTPUT_STROBES,
    output logic             FLAG_OUTPUT_PIN,
    input  wire logic        SINGLE_INPUT_PIN,
    output logic             SINGLE_PIN_LATCH,
    output logic             SKIP_NEXT,
    output logic      [3:0]  WAKEUP_CONTROL_ZERO,
    output logic      [3:0]  WAKEUP_CONTROL_ONE,
    output logic      [3:0]  WAKEUP_CONTROL_TWO,
    output logic      [3:0]  PULLUP_CONTROL_ZERO,
    output logic      [3:0]  PULLUP_CONTROL_ONE,
    output logic      [3:0]  PULLUP_CONTROL_TWO
);

    ////////////////////////////////////////////////////////////////////////////
    // state of the whole unit
    typedef struct packed {
        pioiu_bus_t  bus;
        logic [31:0] rdata;
        logic [3:0]  wreg;
        logic [2:0]  ptr;
        logic [4:0]  last_op;
        logic        skip;
        logic        illegal;
        logic [3:0]  p0;
        logic [3:0]  p1;
        logic [1:0]  p2;
        logic [1:0]  p3;
        logic [5:0]  stb;
        logic        flag;
        logic        sgl;
        logic [3:0]  wk0;
        logic [3:0]  wk1;
        logic [3:0]  wk2;
        logic [3:0]  pu0;
        logic [3:0]  pu1;
        logic [3:0]  pu2;
    } pioiu_state_t;

    pioiu_state_t st_r;
    pioiu_state_t st_nxt;

    logic [12:0] pins_sync;
    logic [3:0]  pin_p0;
    logic [3:0]  pin_p1;
    logic [1:0]  pin_p2;
    logic [1:0]  pin_p3;
    logic        pin_sgl;
    logic        bus_req;
    logic        wr_go;
    logic [4:0]  op;
    logic        op_clr;
    logic        op_set;
    logic [5:0]  stb_new;
    logic        stb_sel;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////////
    // all pin inputs pass two flops before any instruction samples them
    pioiu_sync #(
        .W    (13)
    ) u_sync (
        .clk  (CLK_SYS),
        .rst  (SYS_RST),
        .din  ({SINGLE_INPUT_PIN, PORT_THREE_IN, PORT_TWO_IN, PORT_ONE_IN,
                PORT_ZERO_IN}),
        .dout (pins_sync)
    );

    // unpack the synchronised pin levels
    assign pin_p0  = pins_sync[3:0];
    assign pin_p1  = pins_sync[7:4];
    assign pin_p2  = pins_sync[9:8];
    assign pin_p3  = pins_sync[11:10];
    assign pin_sgl = pins_sync[12];

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: every access waits one cycle, write acts on release edge
    assign bus_req         = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = bus_req & (st_r.bus == BUS_IDLE);
    assign wr_go           = AVS_WRITE & (st_r.bus == BUS_ACK) & AVS_BYTEENABLE[0];
    assign op              = AVS_WRITEDATA[4:0];
    assign op_clr          = wr_go & (AVS_ADDRESS == OFF_CMD) & (op == OP_STB_CLR);
    assign op_set          = wr_go & (AVS_ADDRESS == OFF_CMD) & (op == OP_STB_SET);

    ////////////////////////////////////////////////////////////////////////////
    // pointer-addressed strobe bit logic
    pioiu_bitop u_bitop (
        .stb     (st_r.stb),
        .ptr     (st_r.ptr),
        .do_clr  (op_clr),
        .do_set  (op_set),
        .stb_new (stb_new),
        .sel_bit (stb_sel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses read as zero
    always_comb begin
        rd_mux = RST_WORD;
        case (AVS_ADDRESS)
            OFF_CMD: begin
                rd_mux[4:0] = st_r.last_op;
            end
            OFF_WORK: begin
                rd_mux[3:0] = st_r.wreg;
            end
            OFF_PTR: begin
                rd_mux[2:0] = st_r.ptr;
            end
            OFF_STATUS: begin
                rd_mux[ST_SKIP_BIT] = st_r.skip;
                rd_mux[ST_FLAG_BIT] = st_r.flag;
                rd_mux[ST_ILL_BIT]  = st_r.illegal;
            end
            OFF_STROBES: begin
                rd_mux[5:0] = st_r.stb;
            end
            OFF_LATCH: begin
                rd_mux[LAT_P0_LSB +: 4] = st_r.p0;
                rd_mux[LAT_P1_LSB +: 4] = st_r.p1;
                rd_mux[LAT_P2_LSB +: 2] = st_r.p2;
                rd_mux[LAT_P3_LSB +: 2] = st_r.p3;
                rd_mux[LAT_SGL_BIT]     = st_r.sgl;
            end
            OFF_WAKEUP: begin
                rd_mux[CTL0_LSB +: 4] = st_r.wk0;
                rd_mux[CTL1_LSB +: 4] = st_r.wk1;
                rd_mux[CTL2_LSB +: 4] = st_r.wk2;
            end
            default: begin
                rd_mux = RST_WORD;  // pull-up controls have no read path
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state: handshake, register writes and instruction execution
    always_comb begin
        st_nxt = st_r;
        unique case (st_r.bus)
            BUS_IDLE: begin
                if (bus_req) begin
                    st_nxt.bus = BUS_ACK;
                    if (AVS_READ) begin
                        st_nxt.rdata = rd_mux;
                    end
                end
            end
            BUS_ACK: begin
                st_nxt.bus = BUS_IDLE;
            end
        endcase
        if (wr_go) begin
            case (AVS_ADDRESS)
                OFF_WORK: begin
                    st_nxt.wreg = AVS_WRITEDATA[3:0];
                end
                OFF_PTR: begin
                    st_nxt.ptr = AVS_WRITEDATA[2:0];  // 6 and 7 are inert
                end
                OFF_STATUS: begin
                    if (AVS_WRITEDATA[ST_ILL_BIT]) begin
                        st_nxt.illegal = 1'b0;  // write one to clear
                    end
                end
                OFF_CMD: begin
                    st_nxt.last_op = op;
                    st_nxt.skip    = 1'b0;  // skip reflects the latest command only
                    case (op)
                        OP_NOP: begin
                            st_nxt.skip = 1'b0;
                        end
                        OP_IN_P0: begin
                            st_nxt.wreg = pin_p0;
                        end
                        OP_OUT_P0: begin
                            st_nxt.p0 = st_r.wreg;
                        end
                        OP_IN_P1: begin
                            st_nxt.wreg = pin_p1;
                        end
                        OP_OUT_P1: begin
                            st_nxt.p1 = st_r.wreg;
                        end
                        OP_IN_P2: begin
                            st_nxt.wreg = pioiu_zext2(pin_p2);
                        end
                        OP_OUT_P2: begin
                            st_nxt.p2 = st_r.wreg[1:0];
                        end
                        OP_IN_P3: begin
                            st_nxt.wreg = pioiu_zext2(pin_p3);
                        end
                        OP_OUT_P3: begin
                            st_nxt.p3 = st_r.wreg[1:0];
                        end
                        OP_STB_ALL: begin
                            st_nxt.stb = STB_ALL;
                        end
                        OP_STB_CLR, OP_STB_SET: begin
                            st_nxt.stb = stb_new;
                        end
                        OP_STB_TST: begin
                            st_nxt.skip = ~stb_sel;
                        end
                        OP_FLG_SET: begin
                            st_nxt.flag = 1'b1;
                        end
                        OP_FLG_CLR: begin
                            st_nxt.flag = 1'b0;
                        end
                        OP_FLG_TST: begin
                            st_nxt.skip = st_r.flag;
                        end
                        OP_IN_SGL: begin
                            st_nxt.wreg = pioiu_zext1(pin_sgl);
                        end
                        OP_OUT_SGL: begin
                            st_nxt.sgl = st_r.wreg[0];
                        end
                        OP_WR_WK0: begin
                            st_nxt.wk0 = st_r.wreg;
                        end
                        OP_WR_WK1: begin
                            st_nxt.wk1 = st_r.wreg;
                        end
                        OP_WR_WK2: begin
                            st_nxt.wk2 = st_r.wreg;
                        end
                        OP_RD_WK0: begin
                            st_nxt.wreg = st_r.wk0;
                        end
                        OP_RD_WK1: begin
                            st_nxt.wreg = st_r.wk1;
                        end
                        OP_RD_WK2: begin
                            st_nxt.wreg = st_r.wk2;
                        end
                        OP_WR_PU0: begin
                            st_nxt.pu0 = st_r.wreg;
                        end
                        OP_WR_PU1: begin
                            st_nxt.pu1 = st_r.wreg;
                        end
                        OP_WR_PU2: begin
                            st_nxt.pu2 = st_r.wreg;
                        end
                        default: begin
                            st_nxt.illegal = 1'b1;  // unknown code: sets illegal, otherwise acts as a nop
                        end
                    endcase
                end
                default: begin
                    st_nxt.illegal = st_r.illegal;  // read-only or unmapped: ignored
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register with synchronous reset
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            st_r.bus     <= BUS_IDLE;
            st_r.rdata   <= RST_WORD;
            st_r.wreg    <= RST_NIBBLE;
            st_r.ptr     <= RST_PTR;
            st_r.last_op <= RST_OP;
            st_r.skip    <= 1'b0;
            st_r.illegal <= 1'b0;
            st_r.p0      <= RST_NIBBLE;
            st_r.p1      <= RST_NIBBLE;
            st_r.p2      <= RST_PAIR;
            st_r.p3      <= RST_PAIR;
            st_r.stb     <= RST_STB;
            st_r.flag    <= 1'b0;
            st_r.sgl     <= 1'b0;
            st_r.wk0     <= RST_NIBBLE;
            st_r.wk1     <= RST_NIBBLE;
            st_r.wk2     <= RST_NIBBLE;
            st_r.pu0     <= RST_NIBBLE;
            st_r.pu1     <= RST_NIBBLE;
            st_r.pu2     <= RST_NIBBLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // all outputs but AVS_WAITREQUEST come straight from flops
    assign AVS_READDATA        = st_r.rdata;
    assign PORT_ZERO_OUT       = st_r.p0;
    assign PORT_ONE_OUT        = st_r.p1;
    assign PORT_TWO_OUT        = st_r.p2;
    assign PORT_THREE_OUT      = st_r.p3;
    assign OUTPUT_STROBES      = st_r.stb;
    assign FLAG_OUTPUT_PIN     = st_r.flag;
    assign SINGLE_PIN_LATCH    = st_r.sgl;
    assign SKIP_NEXT           = st_r.skip;
    assign WAKEUP_CONTROL_ZERO = st_r.wk0;
    assign WAKEUP_CONTROL_ONE  = st_r.wk1;
    assign WAKEUP_CONTROL_TWO  = st_r.wk2;
    assign PULLUP_CONTROL_ZERO = st_r.pu0;
    assign PULLUP_CONTROL_ONE  = st_r.pu1;
    assign PULLUP_CONTROL_TWO  = st_r.pu2;

endmodule : pioiu_top
`default_nettype wire

/* File: pioiu_pkg.sv */
// Purpose: constants, opcodes and helpers shared by the port instruction unit
// Assumes: 32-bit avalon-mm data, byte addresses, registers on aligned words
// Notes:   opcode values and register offsets are local to this block
package pioiu_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus geometry and register offsets (byte addresses)
    localparam int         AV_ADDR_W   = 6;
    localparam logic [5:0] OFF_CMD     = 6'h00;
    localparam logic [5:0] OFF_WORK    = 6'h04;
    localparam logic [5:0] OFF_PTR     = 6'h08;
    localparam logic [5:0] OFF_STATUS  = 6'h0C;
    localparam logic [5:0] OFF_STROBES = 6'h10;
    localparam logic [5:0] OFF_LATCH   = 6'h14;
    localparam logic [5:0] OFF_WAKEUP  = 6'h18;
    localparam logic [5:0] OFF_PULLUP  = 6'h1C;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int ST_SKIP_BIT  = 0;
    localparam int ST_FLAG_BIT  = 1;
    localparam int ST_ILL_BIT   = 2;
    localparam int LAT_P0_LSB   = 0;
    localparam int LAT_P1_LSB   = 4;
    localparam int LAT_P2_LSB   = 8;
    localparam int LAT_P3_LSB   = 10;
    localparam int LAT_SGL_BIT  = 12;
    localparam int CTL0_LSB     = 0;
    localparam int CTL1_LSB     = 4;
    localparam int CTL2_LSB     = 8;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and limits
    localparam logic [3:0]  RST_NIBBLE = 4'h0;
    localparam logic [1:0]  RST_PAIR   = 2'h0;
    localparam logic [5:0]  RST_STB    = 6'h00;
    localparam logic [2:0]  RST_PTR    = 3'h0;
    localparam logic [4:0]  RST_OP     = 5'h00;
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;
    localparam logic [2:0]  PTR_MAX    = 3'h5;
    localparam logic [5:0]  STB_ONE    = 6'h01;
    localparam logic [5:0]  STB_ALL    = 6'h3F;

    ////////////////////////////////////////////////////////////////////////////
    // instruction codes written to the command register
    localparam logic [4:0] OP_NOP      = 5'h00;
    localparam logic [4:0] OP_IN_P0    = 5'h01;
    localparam logic [4:0] OP_OUT_P0   = 5'h02;
    localparam logic [4:0] OP_IN_P1    = 5'h03;
    localparam logic [4:0] OP_OUT_P1   = 5'h04;
    localparam logic [4:0] OP_IN_P2    = 5'h05;
    localparam logic [4:0] OP_OUT_P2   = 5'h06;
    localparam logic [4:0] OP_IN_P3    = 5'h07;
    localparam logic [4:0] OP_OUT_P3   = 5'h08;
    localparam logic [4:0] OP_STB_ALL  = 5'h09;
    localparam logic [4:0] OP_STB_CLR  = 5'h0A;
    localparam logic [4:0] OP_STB_SET  = 5'h0B;
    localparam logic [4:0] OP_STB_TST  = 5'h0C;
    localparam logic [4:0] OP_FLG_SET  = 5'h0D;
    localparam logic [4:0] OP_FLG_CLR  = 5'h0E;
    localparam logic [4:0] OP_FLG_TST  = 5'h0F;
    localparam logic [4:0] OP_IN_SGL   = 5'h10;
    localparam logic [4:0] OP_OUT_SGL  = 5'h11;
    localparam logic [4:0] OP_WR_WK0   = 5'h12;
    localparam logic [4:0] OP_WR_WK1   = 5'h13;
    localparam logic [4:0] OP_WR_WK2   = 5'h14;
    localparam logic [4:0] OP_RD_WK0   = 5'h15;
    localparam logic [4:0] OP_RD_WK1   = 5'h16;
    localparam logic [4:0] OP_RD_WK2   = 5'h17;
    localparam logic [4:0] OP_WR_PU0   = 5'h18;
    localparam logic [4:0] OP_WR_PU1   = 5'h19;
    localparam logic [4:0] OP_WR_PU2   = 5'h1A;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } pioiu_bus_t;

    // widen a two-bit port value, upper bits cleared
    function automatic logic [3:0] pioiu_zext2(input logic [1:0] v);
        return {2'b00, v};
    endfunction : pioiu_zext2

    // widen a single pin level, upper bits cleared
    function automatic logic [3:0] pioiu_zext1(input logic v);
        return {3'b000, v};
    endfunction : pioiu_zext1

endpackage : pioiu_pkg

/* File: pioiu_sync.sv */
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to CLK_SYS
// Notes:   stage one feeds stage two only
`timescale 1ns/10ps
`default_nettype none
module pioiu_sync #(
    parameter int W = 13
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pioiu_sync_t;

    pioiu_sync_t r_r;
    pioiu_sync_t r_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // shift pins through two flops
    always_comb begin
        r_nxt    = r_r;
        r_nxt.s1 = din;
        r_nxt.s2 = r_r.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign dout = r_r.s2;

endmodule : pioiu_sync
`default_nettype wire

/* File: pioiu_bitop.sv */
// Purpose: pointer-addressed bit clear, set and test on the strobe port
// Assumes: pointer values above five select no bit
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
module pioiu_bitop import pioiu_pkg::*; (
    input  wire logic [5:0] stb,
    input  wire logic [2:0] ptr,
    input  wire logic       do_clr,
    input  wire logic       do_set,
    output logic      [5:0] stb_new,
    output logic            sel_bit
);

    logic [5:0] mask;

    ////////////////////////////////////////////////////////////////////////////
    // one-hot mask; out-of-range pointer touches nothing and tests as one
    always_comb begin
        mask    = (ptr <= PTR_MAX) ? (STB_ONE << ptr) : 6'h00;
        stb_new = stb;
        if (do_clr) begin
            stb_new = stb & ~mask;
        end else if (do_set) begin
            stb_new = stb | mask;
        end
        sel_bit = (ptr <= PTR_MAX) ? stb[ptr] : 1'b1;
    end

endmodule : pioiu_bitop
`default_nettype wire

/* File: pioiu_pins.sv */
// Purpose: board-side pin levels for the port instruction unit
// Assumes: levels change only just after a clock edge
// Notes:   one register stage stands in for board settling
`timescale 1ns/10ps
`default_nettype none
module pioiu_pins (
    input  wire logic        clk,
    input  wire logic [12:0] lvl,
    output logic      [12:0] pins
);
    // pins start low so the synchroniser never sees an unknown
    initial pins = 13'h0000;
    always @(posedge clk) pins <= lvl;
endmodule : pioiu_pins
`default_nettype wire

/* File: pioiu_checker.sv */
// Purpose: timing properties of the port instruction unit
// Assumes: one clock, synchronous active-high reset
// Notes:   pointer is not visible here, bit ops judged by change counts
`timescale 1ns/10ps
`default_nettype none
module pioiu_checker import pioiu_pkg::*; (
    input wire logic        CLK_SYS,
    input wire logic        SYS_RST,
    input wire logic [5:0]  AVS_ADDRESS,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic        AVS_WAITREQUEST,
    input wire logic [3:0]  PORT_ZERO_OUT,
    input wire logic [5:0]  OUTPUT_STROBES,
    input wire logic        FLAG_OUTPUT_PIN,
    input wire logic        SKIP_NEXT,
    input wire logic [3:0]  PULLUP_CONTROL_ZERO
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////
    // a command is taken at the edge where waitrequest is low
    logic       go;
    logic [4:0] op;
    assign go = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFF_CMD && AVS_BYTEENABLE[0];
    assign op = AVS_WRITEDATA[4:0];
    a_clr_one_bit: assert property (go && op == OP_STB_CLR |=>
        $countones(OUTPUT_STROBES ^ $past(OUTPUT_STROBES)) <= 1 &&
        (OUTPUT_STROBES & ~$past(OUTPUT_STROBES)) == 6'h00) else $error("strobe clear bad");
    a_set_one_bit: assert property (go && op == OP_STB_SET |=>
        $countones(OUTPUT_STROBES ^ $past(OUTPUT_STROBES)) <= 1 &&
        (~OUTPUT_STROBES & $past(OUTPUT_STROBES)) == 6'h00) else $error("strobe set bad");
    a_test_skip: assert property (go && op == OP_STB_TST |=> $stable(OUTPUT_STROBES) &&
        (!SKIP_NEXT || $past(OUTPUT_STROBES) != STB_ALL)) else $error("strobe test bad");
    a_flag_set: assert property (go && op == OP_FLG_SET |=> FLAG_OUTPUT_PIN)
        else $error("flag not set");
    a_flag_clr: assert property (go && op == OP_FLG_CLR |=> !FLAG_OUTPUT_PIN)
        else $error("flag not cleared");
    a_flag_test: assert property (go && op == OP_FLG_TST |=>
        SKIP_NEXT == $past(FLAG_OUTPUT_PIN)) else $error("flag test bad");
    a_p0_hold: assert property (go && op != OP_OUT_P0 |=> $stable(PORT_ZERO_OUT))
        else $error("port zero changed");
    a_pu0_hold: assert property (go && op != OP_WR_PU0 |=> $stable(PULLUP_CONTROL_ZERO))
        else $error("pull-up zero changed");
endmodule : pioiu_checker
bind pioiu_top pioiu_checker chk_u (.CLK_SYS, .SYS_RST, .AVS_ADDRESS, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_WAITREQUEST, .PORT_ZERO_OUT, .OUTPUT_STROBES,
    .FLAG_OUTPUT_PIN, .SKIP_NEXT, .PULLUP_CONTROL_ZERO);
`default_nettype wire

/* File: pioiu_tb_top.sv */
// Purpose: self-checking bench for the port instruction unit
// Assumes: every avalon-mm access is answered, one wait state
// Notes:   reads note their expected word, a monitor compares
`timescale 1ns/10ps
`default_nettype none
module pioiu_tb_top import pioiu_pkg::*; ;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [12:0] lvl = 13'h0000;
    logic [31:0] rdat;
    logic        wreq;
    wire  [12:0] pins;
    wire  [12:0] lato;
    wire  [11:0] puo;
    wire  [11:0] wko;
    logic [31:0] q[$];
    int          err_total = 0;
    int          comparisons = 0;
    int          cyc = 0;
    always #5 clk = ~clk;
    pioiu_pins pins_u (.clk(clk), .lvl(lvl), .pins(pins));
    pioiu_top dut_u (.CLK_SYS(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .PORT_ZERO_IN(pins[3:0]), .PORT_ZERO_OUT(lato[3:0]),
        .PORT_ONE_IN(pins[7:4]), .PORT_ONE_OUT(lato[7:4]), .PORT_TWO_IN(pins[9:8]),
        .PORT_TWO_OUT(lato[9:8]), .PORT_THREE_IN(pins[11:10]), .PORT_THREE_OUT(lato[11:10]),
        .OUTPUT_STROBES(), .FLAG_OUTPUT_PIN(), .SINGLE_INPUT_PIN(pins[12]),
        .SINGLE_PIN_LATCH(lato[12]), .SKIP_NEXT(), .WAKEUP_CONTROL_ZERO(wko[3:0]),
        .WAKEUP_CONTROL_ONE(wko[7:4]), .WAKEUP_CONTROL_TWO(wko[11:8]),
        .PULLUP_CONTROL_ZERO(puo[3:0]),
        .PULLUP_CONTROL_ONE(puo[7:4]), .PULLUP_CONTROL_TWO(puo[11:8]));
    ////////////////////////////////////////
    task automatic conclude();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    // held until waitrequest is sampled low, released only after that edge
    task automatic bus(input logic r, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= r;
        wr <= !r;
        adr <= a;
        wdat <= d;
        @(posedge clk iff !wreq);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rdx(input logic [5:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b1, a, 32'h0000_0000);
    endtask : rdx
    task automatic cmd(input logic [4:0] op);
        bus(1'b0, OFF_CMD, 32'(op));
    endtask : cmd
    // lane position and width of port i in the latch image
    function automatic int shf(input int i);
        return i < 2 ? 4 * i : 4 + 2 * i;
    endfunction : shf
    function automatic logic [3:0] msk(input int i);
        return i < 2 ? 4'hF : (i < 4 ? 4'h3 : 4'h1);
    endfunction : msk
    ////////////////////////////////////////
    // oldest note against each read word
    always @(posedge clk iff (rd && !wreq)) begin
        if (q.size() == 0) cmp("read queue", 32'h0000_0001, 32'h0000_0000);
        else cmp("readdata", q.pop_front(), rdat);
    end
    // hang guard, well above the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            conclude();
        end
    end
    initial begin : main
        logic [12:0] v;
        logic [12:0] lat;
        logic [11:0] wk;
        logic [5:0]  s;
        logic [3:0]  w;
        v = 13'($urandom(32'h0963));
        lat = 13'h0000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int n = 0; n < 3; n++) begin
            v = 13'($urandom);
            lvl <= v;
            repeat (4) @(posedge clk);
            for (int i = 0; i < 5; i++) begin
                cmd(i == 4 ? OP_IN_SGL : OP_IN_P0 + 5'(2 * i));
                rdx(OFF_WORK, 32'(v >> shf(i)) & 32'(msk(i)));
                w = 4'($urandom);
                bus(1'b0, OFF_WORK, 32'(w));
                cmd(i == 4 ? OP_OUT_SGL : OP_OUT_P0 + 5'(2 * i));
                lat = (lat & ~(13'(msk(i)) << shf(i))) | (13'(w & msk(i)) << shf(i));
                rdx(OFF_LATCH, 32'(lat));
                cmp("latches", 32'(lat), 32'(lato));
            end
        end
        cmd(OP_STB_ALL);
        for (int i = 0; i < 6; i++) begin
            s = 6'h3F;
            s[i] = 1'b0;
            bus(1'b0, OFF_PTR, 32'(i));
            cmd(OP_STB_CLR);
            rdx(OFF_STROBES, 32'(s));
            cmd(OP_STB_TST);
            rdx(OFF_STATUS, 32'h0000_0001);
            cmd(OP_STB_SET);
            cmd(OP_STB_TST);
            rdx(OFF_STATUS, 32'h0000_0000);
            rdx(OFF_STROBES, 32'h0000_003F);
        end
        w = 4'($urandom);
        bus(1'b0, OFF_WORK, 32'(w));
        cmd(OP_FLG_SET);
        cmd(OP_FLG_TST);
        rdx(OFF_STATUS, 32'h0000_0003);
        rdx(OFF_WORK, 32'(w));
        cmd(OP_FLG_CLR);
        cmd(OP_FLG_TST);
        rdx(OFF_STATUS, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            w = 4'($urandom);
            bus(1'b0, OFF_WORK, 32'(w));
            cmd(OP_WR_WK0 + 5'(i));
            cmd(OP_WR_PU0 + 5'(i));
            wk[4*i +: 4] = w;
            bus(1'b0, OFF_WORK, 32'(~w));
            cmp("pullup", 32'(w), 32'(puo[4*i +: 4]));
            cmd(OP_RD_WK0 + 5'(i));
            rdx(OFF_WORK, 32'(w));
        end
        rdx(OFF_WAKEUP, 32'(wk));
        cmp("wakeup", 32'(wk), 32'(wko));
        rdx(OFF_PULLUP, 32'h0000_0000);
        cmd(OP_WR_PU2 + 5'h01);
        rdx(OFF_STATUS, 32'h0000_0004);
        repeat (2) @(posedge clk);
        conclude();
    end
endmodule : pioiu_tb_top
`default_nettype wire
